// ---- core/external_move_instr_stretch_map.vh ----
/*
 * Constants for the external data move timing block: clock-control field
 * positions, reset values, pointer-select SFR address and cycle counts.
 * Assumes four core clocks per machine cycle.
 */
`ifndef EXTERNAL_MOVE_INSTR_STRETCH_MAP_VH
`define EXTERNAL_MOVE_INSTR_STRETCH_MAP_VH

`define CLOCKS_PER_MCYCLE   4
`define STRETCH_LSB         0
`define STRETCH_MSB         2
`define STRETCH_RESET       3'h1
`define CLKCTL_RESET        8'h01
`define PTRSEL_SFR_ADDR     8'h86
`define PTRSEL_BIT          0
`define PTRSEL_RESET        8'h00
`define FETCH_CLOCKS        4
`define STROBE_MIN_CLOCKS   2

`endif

// ---- core/external_move_instr_stretch_access.v ----
/*
 * External data move timing: sequences the opcode fetch, the address phase
 * and a stretched read or write strobe toward off-chip data memory, and
 * freezes the CPU state for the added machine cycles.
 * Assumes the sequencer raises start with the instruction's address sources
 * valid, and that SFR writes arrive as one-cycle strobes from core logic.
 */
// How it works
// - Every external move opens with a normal four-clock opcode fetch cycle.
// - The next machine cycle drives the data address and performs the access.
// - Stretch comes from bits 2-0 of the clock control register.
// - Instruction lasts two machine cycles plus the stretch value, 2 to 9.
// - Only external moves are lengthened; other instructions keep their timing.
// - Stretch resets to one, giving a three machine cycle external move.
// - Strobe lasts 2 clocks at stretch zero, else four clocks per stretch.
// - CPU state is held frozen during the added stretch cycles.
// - Register-indirect uses working register low and port 2 high; else pointer.
// - Pointer select at 86h uses bit 0 only; other bits read zero.
`timescale 1ns/1ns
`include "external_move_instr_stretch_map.vh"

module external_move_instr_stretch_access #(
	parameter AW = 16                  // External address width
) (
	input  wire          clock,         // Core clock, 250 MHz
	input  wire          resetn,        // Asynchronous reset, active low
	input  wire          clk_en,        // Freezes all state but the reset synchronizer while low
	input  wire          start,         // External move instruction begins
	input  wire          is_write,      // Access direction, high for write
	input  wire          use_pointer,   // High: pointer form, low: register form
	input  wire [7:0]    work_reg,      // Selected working register
	input  wire [7:0]    port2_latch,   // Port 2 latch, high address byte
	input  wire [7:0]    wr_data,       // Data for an external write
	input  wire          sfr_wr,        // SFR write strobe
	input  wire [7:0]    sfr_addr,      // SFR address
	input  wire [7:0]    sfr_wdata,     // SFR write data
	input  wire          clkctl_wr,     // Clock control register write strobe
	input  wire          data_pointer_a_a_wr,     // Load first data pointer
	input  wire          data_pointer_a_b_wr,     // Load second data pointer
	input  wire [AW-1:0] data_pointer_a_wdata,    // Data pointer load value
	input  wire [7:0]    ext_rdata,     // Data returned by external memory
	output reg  [7:0]    clock_control_reg, // Clock control register value
	output reg  [7:0]    pointer_select,    // Pointer select register value
	output reg  [AW-1:0] ext_addr,      // External data address
	output reg           ext_rd_n,      // Read strobe, active low
	output reg           ext_wr_n,      // Write strobe, active low
	output reg  [7:0]    ext_wdata,     // Write data toward memory
	output reg           ext_wdata_oe,  // High while driving the data bus
	output reg  [7:0]    rd_result,     // Data captured by a read
	output reg           cpu_hold,      // CPU state frozen while high
	output reg           busy,          // External move in progress
	output reg           done           // One-cycle pulse at instruction end
);

	localparam ST_IDLE  = 2'd0;
	localparam ST_FETCH = 2'd1;
	localparam ST_ACC   = 2'd2;
	localparam ST_TAIL  = 2'd3;

	reg [1:0]    rst_sync_q;
	wire         rst_n = rst_sync_q[1];

	reg [1:0]    state_q;
	reg [5:0]    clk_cnt_q;       // Clocks left in the current phase
	reg [2:0]    stretch_q;       // Captured at start
	reg          write_q;
	reg [AW-1:0] data_pointer_a;
	reg [AW-1:0] data_pointer_b;

	wire [2:0] access_stretch_sel = clock_control_reg[`STRETCH_MSB:`STRETCH_LSB];
	wire [AW-1:0] sel_ptr = pointer_select[`PTRSEL_BIT] ? data_pointer_b : data_pointer_a;
	wire [AW-1:0] ri_addr = {port2_latch, work_reg};

	// Access cycles: (stretch+1) machine cycles; strobe inside them
	wire [5:0] acc_clocks = {stretch_q, 2'b00} + 6'h04;
	wire [5:0] strobe_clocks = (stretch_q == 3'h0) ? 6'h02 : {1'b0, stretch_q, 2'b00};
	// Strobe is centred: one clock of setup at stretch zero, two clocks otherwise
	wire [5:0] strobe_lead = (stretch_q == 3'h0) ? 6'h01 : 6'h02;

	// Phase events; fetch end, strobe edges and hold drop are decoded from the one down-counter that times a move
	wire       in_access   = (state_q == ST_ACC);
	wire       in_tail     = (state_q == ST_TAIL);
	wire       take_start  = (state_q == ST_IDLE) && start;
	wire       fetch_end   = (state_q == ST_FETCH) && (clk_cnt_q == 6'h00);
	wire [5:0] fall_at     = acc_clocks - strobe_lead;
	wire [5:0] rise_at     = fall_at - strobe_clocks;
	wire       strobe_fall = in_access && (clk_cnt_q == fall_at);
	wire       strobe_rise = in_access && (clk_cnt_q == rise_at);
	// Last machine cycle of the access runs unheld so the CPU can pick up the result
	wire       hold_drop   = in_access && (clk_cnt_q == 6'd`CLOCKS_PER_MCYCLE);

	// Reset leaves through two flops so every register lets go on the same edge
	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	// Software can rewrite these mid-move; the captured stretch shields the access length, but pointer select is read at fetch end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clock_control_reg <= `CLKCTL_RESET;
			pointer_select    <= `PTRSEL_RESET;
		end else if (clk_en) begin
			if (clkctl_wr)
				clock_control_reg <= sfr_wdata;
			if (sfr_wr && sfr_addr == `PTRSEL_SFR_ADDR)
				pointer_select <= {7'h00, sfr_wdata[`PTRSEL_BIT]};
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_pointer_a <= {AW{1'b0}};
			data_pointer_b <= {AW{1'b0}};
		end else if (clk_en) begin
			if (data_pointer_a_a_wr)
				data_pointer_a <= data_pointer_a_wdata;
			if (data_pointer_a_b_wr)
				data_pointer_b <= data_pointer_a_wdata;
		end
	end

	// One down-counter times the fetch and the access; the decodes above key off it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ST_IDLE;
			clk_cnt_q <= 6'h00;
			stretch_q <= `STRETCH_RESET;
			write_q   <= 1'b0;
		end else if (clk_en) begin
			case (state_q)
			ST_IDLE: begin
				// Only a start request engages this block; others never see it
				if (take_start) begin
					stretch_q <= access_stretch_sel;
					write_q   <= is_write;
					clk_cnt_q <= 6'd`FETCH_CLOCKS - 6'h01;
					state_q   <= ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (fetch_end) begin
					clk_cnt_q <= acc_clocks - 6'h01;
					state_q   <= ST_ACC;
				end else
					clk_cnt_q <= clk_cnt_q - 6'h01;
			end
			ST_ACC: begin
				clk_cnt_q <= clk_cnt_q - 6'h01;
				if (clk_cnt_q == 6'h00)
					state_q <= ST_TAIL;
			end
			ST_TAIL: begin
				state_q <= ST_IDLE;
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// Address and write data stand from the access cycle until the next move
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_addr     <= {AW{1'b0}};
			ext_wdata    <= 8'h00;
			ext_wdata_oe <= 1'b0;
		end else if (clk_en) begin
			if (fetch_end) begin
				ext_addr     <= use_pointer ? sel_ptr : ri_addr;
				ext_wdata    <= wr_data;
				ext_wdata_oe <= write_q;
			end else if (in_tail) begin
				ext_wdata_oe <= 1'b0;
			end
		end
	end

	// Read data is taken as the strobe rises, the last point it is sure to be valid
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_rd_n  <= 1'b1;
			ext_wr_n  <= 1'b1;
			rd_result <= 8'h00;
		end else if (clk_en) begin
			if (strobe_fall) begin
				ext_rd_n <= write_q;
				ext_wr_n <= ~write_q;
			end
			if (strobe_rise) begin
				if (!write_q)
					rd_result <= ext_rdata;
				ext_rd_n <= 1'b1;
				ext_wr_n <= 1'b1;
			end
		end
	end

	// Busy spans the tail cycle, so a new start is taken no earlier than the done pulse cycle
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cpu_hold <= 1'b0;
			busy     <= 1'b0;
			done     <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (take_start)
				busy <= 1'b1;
			// Hold only when machine cycles beyond the base two are added
			if (fetch_end)
				cpu_hold <= (stretch_q != 3'h0);
			if (hold_drop)
				cpu_hold <= 1'b0;
			if (in_tail) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end

endmodule

// ---- testbench/external_move_instr_stretch_access_monitor.sv ----
/* Checker for the external move timer: fetch, strobe width, length, hold.
   Assumes it is bound to the timer's ports with clk_en held high. */
`timescale 1ns/1ns
module external_move_instr_stretch_access_monitor (
	input wire logic       clock, resetn, start, busy, done, ext_rd_n, ext_wr_n, cpu_hold,
	input wire logic [7:0] clock_control_reg, pointer_select
);
	logic [2:0] s_q;
	logic [5:0] c_q, w_q, h_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Stretch is latched at the take edge, as the design must do
	always @(posedge clock or negedge resetn)
		if (!resetn) {s_q, c_q, w_q, h_q} <= '0;
		else begin
			if (start && !busy) s_q <= clock_control_reg[2:0];
			c_q <= (start && !busy) ? 6'h00 : c_q + 6'h01;
			w_q <= (ext_rd_n && ext_wr_n) ? 6'h00 : w_q + 6'h01;
			h_q <= cpu_hold ? h_q + 6'h01 : 6'h00;
		end
	property p_rst; $rose(resetn) |-> clock_control_reg == 8'h01; endproperty
	property p_ps; pointer_select[7:1] == 7'h00; endproperty
	property p_take; start && !busy |=> busy; endproperty
	property p_fetch; $rose(busy) |-> (ext_rd_n && ext_wr_n && !cpu_hold) [*4]; endproperty
	property p_width;
		$rose(ext_rd_n && ext_wr_n) |-> w_q == (s_q == 3'h0 ? 6'h02 : {1'b0, s_q, 2'b00});
	endproperty
	property p_len; done |-> c_q == 6'h09 + {1'b0, s_q, 2'b00}; endproperty
	property p_hold; $fell(cpu_hold) |-> h_q == {1'b0, s_q, 2'b00}; endproperty
	property p_idle; !busy |-> ext_rd_n && ext_wr_n && !cpu_hold; endproperty
	a_rst: assert property (p_rst) else $error("clock control reset value wrong");
	a_ps: assert property (p_ps) else $error("pointer select upper bits set");
	a_take: assert property (p_take) else $error("start not taken");
	a_fetch: assert property (p_fetch) else $error("access during fetch");
	a_width: assert property (p_width) else $error("strobe width wrong");
	a_len: assert property (p_len) else $error("move length wrong");
	a_hold: assert property (p_hold) else $error("hold length wrong");
	a_idle: assert property (p_idle) else $error("activity outside a move");
	c_short: cover property (done && s_q == 3'h0);
	c_long: cover property (done && s_q == 3'h7);
	c_wr: cover property ($rose(ext_wr_n));
endmodule
bind external_move_instr_stretch_access external_move_instr_stretch_access_monitor mon (.*);

// ---- testbench/ext_mem_model.sv ----
/* Off-chip data memory: writes land on the write strobe's rising edge.
   Assumes the address stands for the whole strobe. */
`timescale 1ns/1ns
module ext_mem_model (
	input wire logic        clock, ext_rd_n, ext_wr_n,
	input wire logic [15:0] ext_addr,
	input wire logic [7:0]  ext_wdata,
	output logic [7:0]      ext_rdata
);
	logic [7:0] mem [0:65535];
	initial ext_rdata = 8'h00;
	always @(posedge ext_wr_n) mem[ext_addr] <= ext_wdata;
	// Released bus toggles so a late sample never reads stale data
	always @(posedge clock) ext_rdata <= ext_rd_n ? ~ext_rdata : mem[ext_addr];
endmodule

// ---- testbench/external_move_instr_stretch_access_tb_top.sv ----
/* Scenario bench for the external move timer.
   Assumes the memory model on the far side and clk_en held high. */
`timescale 1ns/1ns
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin miscompares++; $display("BAD %0t got %h want %h", $time, x, y); end end
module external_move_instr_stretch_access_tb_top;
	logic clock = 0, resetn = 0, clk_en = 1, start = 0, is_write = 0, use_pointer = 0;
	logic sfr_wr = 0, clkctl_wr = 0, data_pointer_a_a_wr = 0, data_pointer_a_b_wr = 0;
	logic [7:0] work_reg = 0, port2_latch = 0, wr_data = 0, sfr_addr = 0, sfr_wdata = 0;
	logic [15:0] data_pointer_a_wdata = 0, ext_addr;
	logic [7:0] ext_rdata, clock_control_reg, pointer_select, ext_wdata, rd_result;
	logic ext_rd_n, ext_wr_n, ext_wdata_oe, cpu_hold, busy, done;
	int miscompares = 0, num_checks = 0;
	external_move_instr_stretch_access uut (.*);
	ext_mem_model far (.*);
	initial forever #2 clock = ~clock;
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task sfr(input logic [7:0] a, d, input logic c);
		@(posedge clock);
		{sfr_wr, clkctl_wr, sfr_addr, sfr_wdata} <= {!c, c, a, d};
		repeat (2) @(posedge clock) {sfr_wr, clkctl_wr} <= 2'b00;
	endtask
	task ld(input logic b, input logic [15:0] v);
		@(posedge clock);
		{data_pointer_a_a_wr, data_pointer_a_b_wr, data_pointer_a_wdata} <= {!b, b, v};
		@(posedge clock);
		{data_pointer_a_a_wr, data_pointer_a_b_wr} <= 2'b00;
	endtask
	task mv(input logic w, p, input logic [15:0] a, input logic [7:0] d, input int s,
		input logic [7:0] cs);
		int k, wl, rl, h, ob;
		@(posedge clock);
		{start, is_write, use_pointer, wr_data} <= {1'b1, w, p, d};
		{port2_latch, work_reg} <= p ? ~a : a;
		@(posedge clock);
		{start, clkctl_wr, sfr_wdata} <= {1'b0, cs != 8'h00, cs};
		k = 1;
		wl = 0;
		rl = 0;
		h = 0;
		ob = 0;
		// Outputs are read 1 ns after the edge, once the design has updated them
		while (done !== 1'b1 && k < 60) begin
			@(posedge clock) clkctl_wr <= 1'b0;
			#1;
			k++;
			if (!ext_wr_n) wl++;
			if (!ext_rd_n) rl++;
			if (cpu_hold) h++;
			if (!ext_wr_n && ext_wdata_oe !== 1'b1) ob++;
		end
		`CHK(k, 10 + 4 * s)
		`CHK(w ? wl : rl, (s == 0) ? 2 : 4 * s)
		`CHK(w ? rl : wl, 0)
		`CHK(h, 4 * s)
		`CHK(ob, 0)
		`CHK(ext_addr, a)
		if (w) `CHK(far.mem[a], d)
		else `CHK(rd_result, d)
	endtask
	task t_reset;
		`CHK(clock_control_reg, 8'h01)
		`CHK(pointer_select, 8'h00)
		mv(1, 0, 16'h3c5a, 8'ha5, 1, 0);
		mv(0, 0, 16'h3c5a, 8'ha5, 1, 0);
	endtask
	task t_stretch;
		for (int s = 0; s < 8; s++) begin
			sfr(8'h00, s[7:0], 1);
			`CHK(clock_control_reg[2:0], s[2:0])
			ld(0, 16'h1200 + s[15:0]);
			mv(1, 1, 16'h1200 + s[15:0], 8'h11 * s[7:0], s, 0);
			mv(0, 0, 16'h1200 + s[15:0], 8'h11 * s[7:0], s, 0);
		end
	endtask
	task t_psel;
		sfr(8'h86, 8'hff, 0);
		`CHK(pointer_select, 8'h01)
		sfr(8'h87, 8'h00, 0);
		`CHK(pointer_select, 8'h01)
		ld(1, 16'hbeef);
		mv(1, 1, 16'hbeef, 8'h5a, 7, 0);
		sfr(8'h86, 8'hfe, 0);
		`CHK(pointer_select, 8'h00)
		mv(0, 1, 16'h1207, 8'h77, 7, 0);
	endtask
	task t_capture;
		sfr(8'h00, 8'h02, 1);
		mv(1, 0, 16'h0042, 8'h3c, 2, 8'h07);
		mv(0, 1, 16'h1207, 8'h77, 7, 0);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset;
		t_stretch;
		t_psel;
		t_capture;
		stop_test;
	end
	initial begin
		#20000;
		miscompares++;
		stop_test;
	end
endmodule
